// ==== hw/irq_mux.sv ====
// interrupt flag latches and the two selectable interrupt lines
`timescale 1ns/1ns
`default_nettype none
module irq_mux
	import trx_pkg::*;
#(
	parameter int N = IRQ_SRCS, // number of sources
	parameter logic [IRQ_SRCS-1:0] LATCH = LATCH_MASK // sources held until cleared
) (
	input wire logic clk_sys, // system clock
	input wire logic sys_rst, // async reset, active high
	input wire logic clk_en, // freezes all state while low
	input wire logic [N-1:0] src_level, // self-clearing sources
	input wire logic [N-1:0] src_set, // event pulses for latched sources
	input wire logic [N-1:0] flag_clear, // host clear, one bit per source
	input wire logic [SEL_W-1:0] sel_one, // source for line one
	input wire logic [SEL_W-1:0] sel_two, // source for line two
	input wire logic invert, // lines active low when set
	output logic irq_one_r, // interrupt line one
	output logic irq_two_r, // interrupt line two
	output logic [N-1:0] latched_r // held flags
);
	logic [N-1:0] merged;

	function automatic logic pick(input logic [N-1:0] v, input logic [SEL_W-1:0] s);
		return (int'(s) < N) ? v[s] : 1'b0;
	endfunction

	// latched events, a set in the clearing cycle wins
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			latched_r <= '0;
		end else if (clk_en) begin
			latched_r <= ((latched_r & ~flag_clear) | src_set) & LATCH;
		end
	end

	assign merged = (src_level & ~LATCH) | latched_r;

	// same map for both lines, polarity applied last
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irq_one_r <= 1'b0;
			irq_two_r <= 1'b0;
		end else if (clk_en) begin
			irq_one_r <= pick(merged, sel_one) ^ invert;
			irq_two_r <= pick(merged, sel_two) ^ invert;
		end
	end

	latch_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !clk_en)
		(latched_r[3] && !flag_clear[3]) |=> latched_r[3])
		else $error("latched flag dropped without a clear");
	set_wins_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !clk_en)
		(src_set[8] && flag_clear[8]) |=> latched_r[8])
		else $error("event lost in clearing cycle");
	polarity_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !clk_en)
		(invert && merged == '0)[*2] |-> (irq_one_r && irq_two_r))
		else $error("inverted idle line not high");
endmodule // irq_mux
`default_nettype wire

// ==== hw/settle_timer.sv ====
// down-counter that times one state transition
`timescale 1ns/1ns
`default_nettype none
module settle_timer
	import trx_pkg::*;
#(
	parameter int W = CNT_W // counter width
) (
	input wire logic clk_sys, // system clock
	input wire logic sys_rst, // async reset, active high
	input wire logic clk_en, // freezes the count while low
	input wire logic start, // load a new count
	input wire logic [W-1:0] count, // cycles until done
	output logic [W-1:0] left_r, // cycles still to run
	output logic done // high in the last counted cycle
);
	// load or count down to zero
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			left_r <= '0;
		end else if (clk_en) begin
			if (start) begin
				left_r <= count;
			end else if (left_r != '0) begin
				left_r <= left_r - W'(1);
			end
		end
	end

	assign done = (left_r == W'(1));

	count_down_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(clk_en && !start && left_r != '0) |=> (left_r == $past(left_r) - W'(1)))
		else $error("settle timer did not count down");
endmodule // settle_timer
`default_nettype wire

// ==== hw/trx_state_ctrl.sv ====
// transceiver operating-state controller with interrupt routing
`timescale 1ns/1ns
`default_nettype none
module trx_state_ctrl
	import trx_pkg::*;
#(
	parameter int SYNTH_CYCLES = SYNTH_CYC, // synth calibration and settling
	parameter int XTAL_CYCLES = XTAL_CYC, // crystal start and settling
	parameter int CAL_CYCLES = CAL_CYC // module calibration after crystal
) (
	input wire logic clk_sys, // system clock, 100 MHz
	input wire logic sys_rst, // async reset, active high
	input wire logic clk_en, // freezes all state while low
	input wire logic cmd_valid, // command register written this cycle
	input wire logic [7:0] state_command_register, // command byte
	input wire logic wake_enable, // wake-up function on
	input wire logic system_clock_output_enable, // clock output to pin requested
	input wire logic [4:0] irq_line_one_source_select, // line one source
	input wire logic [4:0] irq_line_two_source_select, // line two source
	input wire logic irq_polarity_invert, // lines active low
	input wire logic [25:0] irq_flag_clear, // clears latched flags
	input wire logic signal_strength_valid, // level
	input wire logic preamble_found, // event pulse
	input wire logic sync_word_found, // event pulse
	input wire logic node_id_found, // event pulse
	input wire logic crc_correct, // event pulse
	input wire logic packet_received_flag, // event pulse
	input wire logic sleep_counter_expired, // event pulse
	input wire logic receive_counter_expired, // event pulse
	input wire logic transmit_done, // event pulse
	input wire logic rcv_queue_not_empty, // level
	input wire logic rcv_queue_over_threshold, // level
	input wire logic rcv_queue_full, // level
	input wire logic rcv_queue_byte_pulse, // one pulse per byte
	input wire logic rcv_queue_overflow, // level
	input wire logic xmt_queue_not_empty, // level
	input wire logic xmt_queue_over_threshold, // level
	input wire logic xmt_queue_full, // level
	input wire logic low_battery_flag, // level
	input wire logic manchester_error, // packet ended by code error
	input wire logic node_id_error, // packet ended by address error
	input wire logic collision_detected, // packet ended by collision
	output logic [3:0] state_code_r, // current state code
	output logic transition_busy_r, // a timed transition runs
	output logic fifo_access_allow_r, // fifo may be accessed
	output logic reg_write_allow_r, // registers may be changed
	output logic low_freq_oscillator_run_r, // slow oscillator on
	output logic sleep_counter_run_r, // sleep counter on
	output logic xtal_run_r, // crystal on
	output logic digital_ldo_run_r, // digital regulator on
	output logic system_clock_output_en_r, // clock driven to pin
	output logic decoder_reset_r, // one-cycle decoder reset
	output logic decoder_wait_r, // decoder halted for host
	output logic irq_line_one, // interrupt line one
	output logic irq_line_two // interrupt line two
);
	localparam int POWERUP_CYCLES = XTAL_CYCLES + CAL_CYCLES;

	op_e cur_r;
	op_e tgt_r;
	op_e req_tgt;
	cmd_e cmd_k;
	logic busy_r;
	logic boot_r;
	logic is_reset;
	logic accept;
	logic [CNT_W-1:0] req_cost;
	logic tmr_start;
	logic [CNT_W-1:0] tmr_count;
	logic [CNT_W-1:0] tmr_left;
	logic tmr_done;
	logic rx_active;
	logic tx_active;
	logic packet_finished_flag_evt;
	logic [IRQ_SRCS-1:0] src_level;
	logic [IRQ_SRCS-1:0] src_set;
	logic [IRQ_SRCS-1:0] latched;

	function automatic cmd_e decode_cmd(input logic [7:0] b);
		unique case (b)
			CMDB_SOFT_RST: return CMD_RESET;
			CMDB_SLEEP: return CMD_SLEEP;
			CMDB_STBY: return CMD_STBY;
			CMDB_RFS: return CMD_RFS;
			CMDB_TFS: return CMD_TFS;
			CMDB_RX: return CMD_RX;
			CMDB_TX: return CMD_TX;
			CMDB_SWITCH: return CMD_SWITCH;
			default: return CMD_NONE;
		endcase
	endfunction

	function automatic op_e cmd_target(input cmd_e k, input op_e s);
		unique case (k)
			CMD_SLEEP: return ST_SLEEP;
			CMD_STBY: return ST_STBY;
			CMD_RFS: return ST_RFS;
			CMD_TFS: return ST_TFS;
			CMD_RX: return ST_RX;
			CMD_TX: return ST_TX;
			CMD_SWITCH: return (s == ST_RX) ? ST_TX : ST_RX;
			default: return ST_IDLE;
		endcase
	endfunction

	// which moves the state machine will take
	function automatic logic cmd_legal(input cmd_e k, input op_e s, input op_e t);
		logic ok;
		logic rt_pair;
		ok = (s != ST_IDLE) && (t != s) && (k != CMD_NONE) && (k != CMD_RESET);
		rt_pair = (s == ST_RX && t == ST_TX) || (s == ST_TX && t == ST_RX);
		if (s == ST_RFS && t == ST_TX) begin
			ok = 1'b0;
		end
		if (s == ST_TFS && t == ST_RX) begin
			ok = 1'b0;
		end
		if (k == CMD_SWITCH && !rt_pair) begin
			ok = 1'b0;
		end
		if (k != CMD_SWITCH && rt_pair) begin
			ok = 1'b0;
		end
		return ok;
	endfunction

	// settling cycles for a move, zero when it completes at once
	function automatic logic [CNT_W-1:0] settle_cost(input op_e s, input op_e t);
		int c;
		c = 0;
		if (t == ST_STBY && s == ST_SLEEP) begin
			c = XTAL_CYCLES;
		end
		if (t inside {ST_RFS, ST_TFS, ST_RX, ST_TX}) begin
			if (s == ST_STBY) begin
				c = SYNTH_CYCLES;
			end
			if (s == ST_SLEEP) begin
				c = XTAL_CYCLES + SYNTH_CYCLES;
			end
			if ((s == ST_RFS && t == ST_RX) || (s == ST_TFS && t == ST_TX)) begin
				c = SHORT_CYC;
			end
			if ((s == ST_RX && t == ST_TX) || (s == ST_TX && t == ST_RX)) begin
				c = SYNTH_CYCLES;
			end
		end
		return CNT_W'(c);
	endfunction

	function automatic logic [3:0] state_code(input op_e s);
		unique case (s)
			ST_IDLE: return CODE_IDLE;
			ST_SLEEP: return CODE_SLEEP;
			ST_STBY: return CODE_STBY;
			ST_RFS: return CODE_RFS;
			ST_TFS: return CODE_TFS;
			ST_RX: return CODE_RX;
			ST_TX: return CODE_TX;
			default: return CODE_IDLE;
		endcase
	endfunction

	// command decode; a reset is taken even mid-transition
	assign cmd_k = decode_cmd(state_command_register);
	assign is_reset = cmd_valid && (cmd_k == CMD_RESET);
	assign req_tgt = cmd_target(cmd_k, cur_r);
	assign accept = cmd_valid && !busy_r && cmd_legal(cmd_k, cur_r, req_tgt);
	assign req_cost = settle_cost(cur_r, req_tgt);
	assign tmr_start = boot_r || is_reset || (accept && req_cost != '0);
	assign tmr_count = (boot_r || is_reset) ? CNT_W'(POWERUP_CYCLES) : req_cost;

	settle_timer #(
		.W(CNT_W)
	) u_timer (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.start(tmr_start),
		.count(tmr_count),
		.left_r(tmr_left),
		.done(tmr_done)
	);

	// operating state; the old state stands until the move completes
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cur_r <= ST_IDLE;
			tgt_r <= ST_SLEEP;
			busy_r <= 1'b1;
			boot_r <= 1'b1;
		end else if (clk_en) begin
			boot_r <= 1'b0;
			if (is_reset) begin
				cur_r <= ST_IDLE;
				tgt_r <= ST_SLEEP;
				busy_r <= 1'b1;
			end else if (busy_r && tmr_done) begin
				cur_r <= tgt_r;
				busy_r <= 1'b0;
			end else if (accept && req_cost == '0) begin
				cur_r <= req_tgt;
			end else if (accept) begin
				tgt_r <= req_tgt;
				busy_r <= 1'b1;
			end
		end
	end

	// block enables that follow the state
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_code_r <= CODE_IDLE;
			transition_busy_r <= 1'b0;
			fifo_access_allow_r <= 1'b0;
			reg_write_allow_r <= 1'b0;
			low_freq_oscillator_run_r <= 1'b0;
			sleep_counter_run_r <= 1'b0;
			xtal_run_r <= 1'b0;
			digital_ldo_run_r <= 1'b0;
			system_clock_output_en_r <= 1'b0;
		end else if (clk_en) begin
			state_code_r <= state_code(cur_r);
			transition_busy_r <= busy_r;
			fifo_access_allow_r <= !(cur_r inside {ST_IDLE, ST_SLEEP});
			reg_write_allow_r <= !(cur_r inside {ST_IDLE, ST_SLEEP});
			low_freq_oscillator_run_r <= (cur_r == ST_SLEEP) && wake_enable;
			sleep_counter_run_r <= (cur_r == ST_SLEEP) && wake_enable;
			xtal_run_r <= !(cur_r == ST_SLEEP && !busy_r);
			digital_ldo_run_r <= !(cur_r inside {ST_IDLE, ST_SLEEP});
			system_clock_output_en_r <= system_clock_output_enable
				&& !(cur_r inside {ST_IDLE, ST_SLEEP});
		end
	end

	// packet end handling in the decoder
	assign packet_finished_flag_evt = packet_received_flag || manchester_error
		|| node_id_error || collision_detected;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			decoder_reset_r <= 1'b0;
			decoder_wait_r <= 1'b0;
		end else if (clk_en) begin
			decoder_reset_r <= manchester_error || node_id_error;
			if (collision_detected) begin
				decoder_wait_r <= 1'b1;
			end else if (irq_flag_clear[SRC_PACKET_FINISHED_FLAG]) begin
				decoder_wait_r <= 1'b0;
			end
		end
	end

	// tuning toward a radio state counts as active
	assign rx_active = busy_r ? (tgt_r inside {ST_RFS, ST_RX}) : (cur_r == ST_RX);
	assign tx_active = busy_r ? (tgt_r inside {ST_TFS, ST_TX}) : (cur_r == ST_TX);

	// sources placed at their select codes, highest first
	assign src_level = {1'b0, rx_active || tx_active, low_battery_flag,
		cur_r == ST_TX, cur_r == ST_RX, cur_r inside {ST_RFS, ST_TFS},
		cur_r == ST_STBY, xmt_queue_full, xmt_queue_over_threshold,
		xmt_queue_not_empty, rcv_queue_overflow, rcv_queue_byte_pulse,
		rcv_queue_full, rcv_queue_over_threshold, rcv_queue_not_empty,
		8'h00, signal_strength_valid, tx_active, rx_active};
	assign src_set = {packet_finished_flag_evt, 14'h0000, transmit_done,
		receive_counter_expired, sleep_counter_expired, packet_received_flag,
		crc_correct, node_id_found, sync_word_found, preamble_found,
		3'h0};

	irq_mux #(
		.N(IRQ_SRCS),
		.LATCH(LATCH_MASK)
	) u_irq (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.src_level(src_level),
		.src_set(src_set),
		.flag_clear(irq_flag_clear),
		.sel_one(irq_line_one_source_select),
		.sel_two(irq_line_two_source_select),
		.invert(irq_polarity_invert),
		.irq_one_r(irq_line_one),
		.irq_two_r(irq_line_two),
		.latched_r(latched)
	);

	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (sys_rst || !clk_en);

	code_map_a: assert property ((cur_r == ST_RX)[*2] |-> state_code_r == CODE_RX)
		else $error("receive state code wrong");
	rfs_no_tx_a: assert property ((cur_r == ST_RFS && !busy_r && cmd_valid
		&& cmd_k == CMD_TX) |=> (cur_r == ST_RFS && !busy_r))
		else $error("receive-synth moved toward transmit");
	tfs_no_rx_a: assert property ((cur_r == ST_TFS && !busy_r && cmd_valid
		&& cmd_k == CMD_RX) |=> (cur_r == ST_TFS && !busy_r))
		else $error("transmit-synth moved toward receive");
	sleep_now_a: assert property ((accept && !is_reset && req_tgt == ST_SLEEP)
		|=> (cur_r == ST_SLEEP && !busy_r))
		else $error("sleep entry not immediate");
	stby_now_a: assert property ((accept && !is_reset && cur_r != ST_SLEEP
		&& req_tgt == ST_STBY) |=> cur_r == ST_STBY)
		else $error("standby entry not immediate");
	synth_load_a: assert property ((accept && !is_reset && cur_r == ST_STBY
		&& req_tgt == ST_RFS) |=> (busy_r && tmr_left == CNT_W'(SYNTH_CYCLES)))
		else $error("synth settling not started");
	short_load_a: assert property ((accept && !is_reset && cur_r == ST_RFS
		&& req_tgt == ST_RX) |=> (busy_r && tmr_left == CNT_W'(SHORT_CYC)))
		else $error("receive entry time wrong");
	soft_rst_a: assert property (is_reset |=> (cur_r == ST_IDLE && busy_r
		&& tgt_r == ST_SLEEP))
		else $error("soft reset did not restart power-up");
	sleep_lock_a: assert property ((cur_r == ST_SLEEP)[*2]
		|-> (!fifo_access_allow_r && !reg_write_allow_r))
		else $error("sleep did not lock fifo and registers");
	wake_osc_a: assert property ((cur_r == ST_SLEEP && wake_enable)
		|=> (low_freq_oscillator_run_r && sleep_counter_run_r))
		else $error("wake-up clocks not running in sleep");
	collision_wait_a: assert property (collision_detected |=> (decoder_wait_r
		&& latched[SRC_PACKET_FINISHED_FLAG] && !decoder_reset_r))
		else $error("collision not held for host");

	boot_done_c: cover property (busy_r && tmr_done && tgt_r == ST_SLEEP);
	rx_reached_c: cover property (busy_r && tmr_done && tgt_r == ST_RX);
	switch_c: cover property (accept && cmd_k == CMD_SWITCH);
	refused_c: cover property (cmd_valid && !busy_r && !accept && !is_reset);
endmodule // trx_state_ctrl
`default_nettype wire

// ==== inc/trx_pkg.sv ====
// shared constants and types for the transceiver state controller
package trx_pkg;
	// clock and settling times
	localparam int CLK_MHZ = 100;
	localparam int SYNTH_US = 350;
	localparam int SHORT_US = 20;
	localparam int XTAL_US = 2480;
	localparam int CAL_US = 100;
	localparam int SYNTH_CYC = SYNTH_US * CLK_MHZ;
	localparam int SHORT_CYC = SHORT_US * CLK_MHZ;
	localparam int XTAL_CYC = XTAL_US * CLK_MHZ;
	localparam int CAL_CYC = CAL_US * CLK_MHZ;
	localparam int CNT_W = 20;

	// reported four-bit state codes
	localparam logic [3:0] CODE_IDLE = 4'h0;
	localparam logic [3:0] CODE_SLEEP = 4'h1;
	localparam logic [3:0] CODE_STBY = 4'h2;
	localparam logic [3:0] CODE_RFS = 4'h3;
	localparam logic [3:0] CODE_TFS = 4'h4;
	localparam logic [3:0] CODE_RX = 4'h5;
	localparam logic [3:0] CODE_TX = 4'h6;

	// state command register byte values
	localparam logic [7:0] CMDB_SOFT_RST = 8'hff;
	localparam logic [7:0] CMDB_SLEEP = 8'h10;
	localparam logic [7:0] CMDB_STBY = 8'h02;
	localparam logic [7:0] CMDB_RFS = 8'h04;
	localparam logic [7:0] CMDB_RX = 8'h08;
	localparam logic [7:0] CMDB_TFS = 8'h20;
	localparam logic [7:0] CMDB_TX = 8'h40;
	localparam logic [7:0] CMDB_SWITCH = 8'h80;

	// interrupt source selection
	localparam int IRQ_SRCS = 26;
	localparam int SEL_W = 5;
	localparam int SRC_PACKET_FINISHED_FLAG = 25;
	localparam logic [IRQ_SRCS-1:0] LATCH_MASK = 26'h20007f8;

	typedef enum logic [2:0] {
		ST_IDLE, ST_SLEEP, ST_STBY, ST_RFS, ST_TFS, ST_RX, ST_TX
	} op_e;

	typedef enum logic [3:0] {
		CMD_NONE, CMD_RESET, CMD_SLEEP, CMD_STBY, CMD_RFS,
		CMD_TFS, CMD_RX, CMD_TX, CMD_SWITCH
	} cmd_e;
endpackage

// ==== sim/host_model.sv ====
// host model that writes the state command byte
`timescale 1ns/1ns
`default_nettype none
module host_model (
	input wire logic clk_sys, // system clock
	output logic cmd_valid, // command byte strobe
	output logic [7:0] state_command_register // command byte
);
	// quiet bus before the first command
	initial begin
		cmd_valid = 1'b0;
		state_command_register = 8'h00;
	end
	// one byte per call, held to its sampling edge, then the bus shows its inverse
	task automatic send(input logic [7:0] b);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		state_command_register <= b;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		state_command_register <= ~b;
	endtask
endmodule // host_model
`default_nettype wire

// ==== sim/tb_trx_state_ctrl.sv ====
// self-checking bench for the transceiver state controller
`timescale 1ns/1ns
`default_nettype none
module tb_trx_state_ctrl;
	import trx_pkg::*;
	localparam int S = 40;
	localparam int X = 30;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic cmd_valid;
	logic [7:0] cmd_byte;
	logic wake = 1'b0;
	logic system_clock_output = 1'b0;
	logic inv = 1'b0;
	logic en = 1'b1;
	logic [4:0] sel_one = 5'h00;
	logic [4:0] sel_two = 5'h00;
	logic [25:0] clr = '0;
	logic [25:0] lv = '0;
	logic [25:0] ev = '0;
	logic [3:0] code;
	logic busy, fifo_ok, reg_ok, lfo, slc, xtal, ldo, clk_out, dec_rst, dec_wait, l_one, l_two;
	logic [31:0] rnd = 32'h28a7;
	int fails = 0;
	int n_tests = 0;
	int cyc = 0;
	// free-running system clock
	always #5 clk_sys = ~clk_sys;
	host_model host_i (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .state_command_register(cmd_byte));
	trx_state_ctrl #(.SYNTH_CYCLES(S), .XTAL_CYCLES(X), .CAL_CYCLES(10)) trx_state_ctrl_i (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(en), .cmd_valid(cmd_valid),
		.state_command_register(cmd_byte), .wake_enable(wake), .system_clock_output_enable(system_clock_output),
		.irq_line_one_source_select(sel_one), .irq_line_two_source_select(sel_two),
		.irq_polarity_invert(inv), .irq_flag_clear(clr), .signal_strength_valid(lv[2]),
		.preamble_found(ev[3]), .sync_word_found(ev[4]), .node_id_found(ev[5]),
		.crc_correct(ev[6]), .packet_received_flag(ev[7]), .sleep_counter_expired(ev[8]),
		.receive_counter_expired(ev[9]), .transmit_done(ev[10]), .rcv_queue_not_empty(lv[11]),
		.rcv_queue_over_threshold(lv[12]), .rcv_queue_full(lv[13]),
		.rcv_queue_byte_pulse(lv[14]), .rcv_queue_overflow(lv[15]),
		.xmt_queue_not_empty(lv[16]), .xmt_queue_over_threshold(lv[17]),
		.xmt_queue_full(lv[18]), .low_battery_flag(lv[23]), .manchester_error(ev[0]),
		.node_id_error(ev[1]), .collision_detected(ev[25]), .state_code_r(code),
		.transition_busy_r(busy), .fifo_access_allow_r(fifo_ok), .reg_write_allow_r(reg_ok),
		.low_freq_oscillator_run_r(lfo), .sleep_counter_run_r(slc), .xtal_run_r(xtal),
		.digital_ldo_run_r(ldo), .system_clock_output_en_r(clk_out),
		.decoder_reset_r(dec_rst), .decoder_wait_r(dec_wait), .irq_line_one(l_one),
		.irq_line_two(l_two));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// expected level of a selected source in a settled state
	function automatic logic exp_src(input logic [4:0] s, input logic [3:0] c);
		case (s)
			5'h00: return c == 4'h5;
			5'h01: return c == 4'h6;
			5'h13: return c == 4'h2;
			5'h14: return c == 4'h3 || c == 4'h4;
			5'h15: return c == 4'h5;
			5'h16: return c == 4'h6;
			5'h18: return c == 4'h5 || c == 4'h6;
			default: return s < 5'd26 && !LATCH_MASK[s] && lv[s];
		endcase
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic finish_test;
		if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// hang guard
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fails++;
			finish_test();
		end
	end
	// power and access outputs of a settled state
	task automatic status(input logic [3:0] c);
		logic up;
		up = c >= 4'h2;
		chk("fifo", up, fifo_ok);
		chk("regw", up, reg_ok);
		chk("ldo", up, ldo);
		chk("xtal", c != 4'h1, xtal);
		chk("system_clock_output", up && system_clock_output, clk_out);
		chk("lfo", c == 4'h1 && wake, lfo);
		chk("slcnt", c == 4'h1 && wake, slc);
	endtask
	// random selects, polarity and source levels
	task automatic irq_rand(input int k);
		repeat (k) begin
			rnd = lfsr(rnd);
			@(posedge clk_sys);
			sel_one <= rnd[4:0];
			sel_two <= rnd[9:5];
			inv <= rnd[10];
			lv <= rnd[31:6];
			repeat (2) @(posedge clk_sys);
			#1;
			chk("line1", exp_src(sel_one, code) ^ inv, l_one);
			chk("line2", exp_src(sel_two, code) ^ inv, l_two);
		end
	endtask
	// one command: old code one cycle before t, new code at t
	task automatic step(input logic [7:0] b, input logic [3:0] o, input logic [3:0] n, input int t);
		rnd = lfsr(rnd);
		@(posedge clk_sys);
		wake <= rnd[0];
		system_clock_output <= rnd[1];
		host_i.send(b);
		repeat (t - 2) @(posedge clk_sys);
		#1;
		chk("old", o, code);
		chk("busy", t > 2, busy);
		@(posedge clk_sys);
		#1;
		chk("new", n, code);
		status(n);
		irq_rand(3);
	endtask
	task automatic wait_sleep;
		for (int i = 0; i < 300 && code !== 4'h1; i++) @(posedge clk_sys);
		#1;
		chk("pwrup", 4'h1, code);
	endtask
	// latched events held until cleared, then decoder reactions
	task automatic latch_test;
		int s;
		for (int j = 3; j <= 11; j++) begin
			s = j == 11 ? 25 : j;
			@(posedge clk_sys);
			sel_one <= 5'(s);
			inv <= 1'b0;
			ev[s] <= 1'b1;
			@(posedge clk_sys);
			ev <= '0;
			repeat (2) @(posedge clk_sys);
			#1;
			chk("set", 1'b1, l_one);
			if (s == 25) chk("wait", 1'b1, dec_wait);
			@(posedge clk_sys);
			clr[s] <= 1'b1;
			@(posedge clk_sys);
			clr <= '0;
			repeat (3) @(posedge clk_sys);
			#1;
			chk("clr", 1'b0, l_one);
		end
		@(posedge clk_sys);
		ev[0] <= 1'b1;
		@(posedge clk_sys);
		ev[0] <= 1'b0;
		#1;
		chk("decrst", 1'b1, dec_rst);
		@(posedge clk_sys);
		#1;
		chk("decrst1", 1'b0, dec_rst);
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge clk_sys);
		chk("rst", 4'h0, code);
		sys_rst <= 1'b0;
		wait_sleep();
		step(CMDB_STBY, 4'h1, 4'h2, X + 2);
		step(CMDB_SWITCH, 4'h2, 4'h2, 2);
		step(CMDB_RFS, 4'h2, 4'h3, S + 2);
		step(CMDB_TX, 4'h3, 4'h3, 2);
		step(CMDB_RX, 4'h3, 4'h5, 2002);
		step(CMDB_TX, 4'h5, 4'h5, 2);
		step(CMDB_SWITCH, 4'h5, 4'h6, S + 2);
		step(CMDB_SWITCH, 4'h6, 4'h5, S + 2);
		step(CMDB_STBY, 4'h5, 4'h2, 2);
		step(CMDB_TFS, 4'h2, 4'h4, S + 2);
		step(CMDB_RX, 4'h4, 4'h4, 2);
		step(CMDB_TX, 4'h4, 4'h6, 2002);
		step(CMDB_SLEEP, 4'h6, 4'h1, 2);
		step(CMDB_RX, 4'h1, 4'h5, X + S + 2);
		step(CMDB_SLEEP, 4'h5, 4'h1, 2);
		step(CMDB_TFS, 4'h1, 4'h4, X + S + 2);
		step(CMDB_STBY, 4'h4, 4'h2, 2);
		step(CMDB_TX, 4'h2, 4'h6, S + 2);
		step(CMDB_STBY, 4'h6, 4'h2, 2);
		step(8'h33, 4'h2, 4'h2, 2);
		step(CMDB_RX, 4'h2, 4'h5, S + 2);
		// a command sent while the clock enable is low is never taken
		@(posedge clk_sys);
		en <= 1'b0;
		host_i.send(CMDB_STBY);
		repeat (2) @(posedge clk_sys);
		en <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("frz", 4'h5, code);
		latch_test();
		host_i.send(CMDB_SOFT_RST);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("soft", 4'h0, code);
		wait_sleep();
		finish_test();
	end
endmodule // tb_trx_state_ctrl
`default_nettype wire
